// ### core/hub_req_consts.svh
`ifndef HUB_REQ_CONSTS_SVH
`define HUB_REQ_CONSTS_SVH

// ************************************************
// Request type, request code and descriptor type values
// ************************************************
`define RT_HUB_IN        8'hA0
`define RT_PORT_IN       8'hA3
`define RT_STD_DEV_IN    8'h80
`define RT_HUB_NODIR     7'h20
`define RT_PORT_NODIR    7'h23
`define RQ_GET_STATUS    8'h00
`define RQ_CLR_FEATURE   8'h01
`define RQ_GET_BUS_STAT  8'h02
`define RQ_SET_FEATURE   8'h03
`define RQ_GET_DESC      8'h06
`define RQ_SET_DESC      8'h07
`define DT_NONE          8'h00
`define DT_DEVICE        8'h01
`define DT_CONFIG        8'h02
`define DT_STRING        8'h03
`define DT_HUB           8'h29

// ************************************************
// Port and hub feature selectors
// ************************************************
`define HF_C_LOCAL_POWER 8'h00
`define PF_ENABLE        8'h01
`define PF_SUSPEND       8'h02
`define PF_RESET         8'h04
`define PF_POWER         8'h08
`define PF_C_FIRST       8'h10
`define PF_C_LAST        8'h14

// ************************************************
// Descriptor lengths and field values
// ************************************************
`define LEN_DEVICE       8'h12
`define LEN_CONFIG_TOTAL 8'h19
`define LEN_HUB          8'h09
`define LEN_LANG         8'h04
`define LEN_STATUS       8'h04
`define MIN_PORTS        3'h2
`define ATTR_SELF        8'hE0
`define ATTR_BUS         8'hA0
`define MAXP_DEFAULT     8'h32
`define MAXP_ZERO        8'h00
`define MAXP_FULL        8'hFA
`define CHAR_OC          8'h09
`define CHAR_NO_OC       8'h11
`define PG_DEFAULT       8'h32
`define PG_ZERO          8'h00
`define PG_LONG          8'hFA
`define HUB_CURRENT      8'h64
`define PWR_CTRL_MASK    8'hFF

`endif

// ### core/hub_req_pkg.sv
package hub_req_pkg;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SEND = 2'b01
   } req_state_t;

   typedef enum logic [2:0] {
      K_DEVICE = 3'h0,
      K_CONFIG = 3'h1,
      K_HUB    = 3'h2,
      K_LANG   = 3'h3,
      K_HSTAT  = 3'h4,
      K_PSTAT  = 3'h5
   } reply_kind_t;

   typedef enum logic [2:0] {
      PC_DISABLE   = 3'h0,
      PC_SUSPEND   = 3'h1,
      PC_RESUME    = 3'h2,
      PC_RESET     = 3'h3,
      PC_POWER_ON  = 3'h4,
      PC_POWER_OFF = 3'h5,
      PC_CLR_CHG   = 3'h6
   } port_cmd_t;

endpackage

// ### core/hub_req_unit.sv
`timescale 1ns/1ps
`include "hub_req_consts.svh"

// Functional notes
// - Get hub descriptor accepts type 00 or 29.
// - Clear C_LOCAL_POWER completes with no data.
// - Port features: selector, port number, zero length.
// - Port number must lie in 1..N.
// - Hub and port status return four bytes.
// - Listed unsupported hub requests get STALL.
// - Set PORT_RESET resets then enables port.
// - Enable (clear only), suspend and power selectors act.
// - Clearing change selectors clears change bits.
// - Direction bit ignored where marked don't-care.
// - Device descriptor 18 bytes, ids replaceable.
// - String indices 01/02 only when enabled.
// - Configuration set is 25 bytes total.
// - Attributes E0 self-powered, A0 bus-powered.
// - Max power 32, or 00/FA by config.
// - Interface descriptor fields as documented.
// - Endpoint descriptor 81, 03, 1, FF.
// - Hub descriptor reports 2 to 7 ports.
// - Characteristics 11 in modes 2,6 else 09.
// - Power switching reported per port always.
// - Power-good 32, 00 in modes 3,7, FA.
// - Hub current 64, removable 00, mask FF.
// - Anything unrecognised is answered with STALL, except unknown port feature selectors, which are acked.
module hub_req_unit
   import hub_req_pkg::*;
#(
   parameter logic [15:0] DEVICE_RELEASE = 16'h0001  // Arbitrary value
) (
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   input  wire logic        setup_valid,
   input  wire logic [7:0]  setup_type,
   input  wire logic [7:0]  setup_code,
   input  wire logic [15:0] setup_value,
   input  wire logic [15:0] setup_index,
   input  wire logic [15:0] setup_length,
   output logic             setup_ready,
   output logic             reply_ack,
   output logic             reply_stall,
   output logic             tx_valid,
   input  wire logic        tx_ready,
   output logic [7:0]       tx_data,
   output logic             tx_last,
   input  wire logic        power_source_strap,
   input  wire logic        individual_pwr_strap,
   input  wire logic        option_strap,
   input  wire logic [2:0]  downstream_line_pair,
   input  wire logic [15:0] vendor_id,
   input  wire logic [15:0] product_id,
   input  wire logic        strings_enable,
   input  wire logic        long_power_good,
   input  wire logic [1:0]  max_power_sel,
   input  wire logic [31:0] hub_status_in,
   input  wire logic [31:0] port_status_in,
   output logic [2:0]       status_port,
   output logic             port_cmd_valid,
   output port_cmd_t        port_cmd,
   output logic [2:0]       port_num,
   output logic [2:0]       change_sel
);

   // ************************************************
   // Strap derived fields
   // ************************************************
   logic [2:0] mode;
   logic [2:0] num_ports;
   logic       no_oc;
   logic       no_switch;
   logic [7:0] pg_byte;
   logic [7:0] maxp_byte;

   assign mode = {individual_pwr_strap, option_strap, power_source_strap};
   // Port count comes decoded from the downstream strapping
   assign num_ports = (downstream_line_pair < `MIN_PORTS) ? `MIN_PORTS
                                                         : downstream_line_pair;
   assign no_oc     = (mode == 3'h2) || (mode == 3'h6);
   assign no_switch = (mode == 3'h3) || (mode == 3'h7);

   always_comb begin
      if (no_switch) begin
         pg_byte = `PG_ZERO;
      end else if (long_power_good) begin
         pg_byte = `PG_LONG;
      end else begin
         pg_byte = `PG_DEFAULT;
      end
      unique case (max_power_sel)
         2'h1:    maxp_byte = `MAXP_ZERO;
         2'h2:    maxp_byte = `MAXP_FULL;
         default: maxp_byte = `MAXP_DEFAULT;
      endcase
   end

   // ************************************************
   // Descriptor and status byte source
   // ************************************************
   function automatic logic [7:0] reply_byte(input reply_kind_t k, input logic [4:0] i);
      logic [7:0] b;
      b = 8'h00;
      unique case (k)
         K_DEVICE: begin
            unique case (i)
               5'd0:    b = `LEN_DEVICE;
               5'd1:    b = `DT_DEVICE;
               5'd2:    b = 8'h10;
               5'd3:    b = 8'h01;
               5'd4:    b = 8'h09;
               5'd7:    b = 8'h40;
               5'd8:    b = vendor_id[7:0];
               5'd9:    b = vendor_id[15:8];
               5'd10:   b = product_id[7:0];
               5'd11:   b = product_id[15:8];
               5'd12:   b = DEVICE_RELEASE[7:0];
               5'd13:   b = DEVICE_RELEASE[15:8];
               5'd14:   b = {7'h00, strings_enable};
               5'd15:   b = {6'h00, strings_enable, 1'b0};
               5'd17:   b = 8'h01;
               default: b = 8'h00;
            endcase
         end
         K_CONFIG: begin
            unique case (i)
               5'd0:    b = 8'h09;
               5'd1:    b = `DT_CONFIG;
               5'd2:    b = `LEN_CONFIG_TOTAL;
               5'd4:    b = 8'h01;
               5'd5:    b = 8'h01;
               5'd7:    b = power_source_strap ? `ATTR_SELF : `ATTR_BUS;
               5'd8:    b = maxp_byte;
               5'd9:    b = 8'h09;
               5'd10:   b = 8'h04;
               5'd12:   b = 8'h01;
               5'd13:   b = 8'h01;
               5'd14:   b = 8'h09;
               5'd18:   b = 8'h07;
               5'd19:   b = 8'h05;
               5'd20:   b = 8'h81;
               5'd21:   b = 8'h03;
               5'd22:   b = 8'h01;
               5'd24:   b = 8'hFF;
               default: b = 8'h00;
            endcase
         end
         K_HUB: begin
            unique case (i)
               5'd0:    b = `LEN_HUB;
               5'd1:    b = `DT_HUB;
               5'd2:    b = {5'h00, num_ports};
               // Per-port reporting in every mode, even ganged ones
               5'd3:    b = no_oc ? `CHAR_NO_OC : `CHAR_OC;
               5'd5:    b = pg_byte;
               5'd6:    b = `HUB_CURRENT;
               5'd8:    b = `PWR_CTRL_MASK;
               default: b = 8'h00;
            endcase
         end
         K_LANG: begin
            unique case (i)
               5'd0:    b = `LEN_LANG;
               5'd1:    b = `DT_STRING;
               5'd2:    b = 8'h09;
               5'd3:    b = 8'h04;
               default: b = 8'h00;
            endcase
         end
         K_HSTAT: b = hub_status_in[{i[1:0], 3'h0} +: 8];
         K_PSTAT: b = port_status_in[{i[1:0], 3'h0} +: 8];
         default: b = 8'h00;
      endcase
      return b;
   endfunction

   // ************************************************
   // Request decode
   // ************************************************
   logic        dec_data;
   logic        dec_ack;
   logic        dec_port;
   reply_kind_t dec_kind;
   logic [7:0]  dec_len;
   port_cmd_t   dec_cmd;
   logic [2:0]  dec_chg;
   logic        port_ok;
   logic        no_dir_hub;
   logic        no_dir_port;
   logic [7:0]  sel;
   logic [7:0]  dtype;

   assign sel   = setup_value[7:0];
   assign dtype = setup_value[15:8];
   // Direction bit is a don't-care for the feature requests
   assign no_dir_hub  = (setup_type[6:0] == `RT_HUB_NODIR);
   assign no_dir_port = (setup_type[6:0] == `RT_PORT_NODIR);
   assign port_ok = (setup_index[15:8] == 8'h00) && (setup_index[7:3] == 5'h00)
                    && (setup_index[2:0] != 3'h0)
                    && (setup_index[2:0] <= num_ports);

   always_comb begin
      dec_data = 1'b0;
      dec_ack  = 1'b0;
      dec_port = 1'b0;
      dec_kind = K_DEVICE;
      dec_len  = 8'h00;
      dec_cmd  = PC_DISABLE;
      dec_chg  = 3'h0;
      // Everything not matched below falls through to STALL
      if (setup_type == `RT_HUB_IN && setup_code == `RQ_GET_DESC
          && (dtype == `DT_NONE || dtype == `DT_HUB)) begin
         dec_data = 1'b1;
         dec_kind = K_HUB;
         dec_len  = `LEN_HUB;
      end else if (setup_type == `RT_STD_DEV_IN && setup_code == `RQ_GET_DESC) begin
         if (dtype == `DT_DEVICE && sel == 8'h00) begin
            dec_data = 1'b1;
            dec_kind = K_DEVICE;
            dec_len  = `LEN_DEVICE;
         end else if (dtype == `DT_CONFIG && sel == 8'h00) begin
            dec_data = 1'b1;
            dec_kind = K_CONFIG;
            dec_len  = `LEN_CONFIG_TOTAL;
         end else if (dtype == `DT_STRING && sel == 8'h00 && strings_enable) begin
            dec_data = 1'b1;
            dec_kind = K_LANG;
            dec_len  = `LEN_LANG;
         end
      end else if (setup_type == `RT_HUB_IN && setup_code == `RQ_GET_STATUS
                   && setup_value == 16'h0000 && setup_index == 16'h0000) begin
         dec_data = 1'b1;
         dec_kind = K_HSTAT;
         dec_len  = `LEN_STATUS;
      end else if (setup_type == `RT_PORT_IN && setup_code == `RQ_GET_STATUS
                   && setup_value == 16'h0000 && port_ok) begin
         dec_data = 1'b1;
         dec_kind = K_PSTAT;
         dec_len  = `LEN_STATUS;
      end else if (no_dir_hub && setup_code == `RQ_CLR_FEATURE
                   && setup_value == 16'h0000 && setup_index == 16'h0000
                   && setup_length == 16'h0000) begin
         dec_ack = 1'b1;
      end else if (no_dir_port && setup_length == 16'h0000 && port_ok
                   && setup_value[15:8] == 8'h00
                   && (setup_code == `RQ_CLR_FEATURE
                       || setup_code == `RQ_SET_FEATURE)) begin
         dec_ack = 1'b1;
         if (setup_code == `RQ_SET_FEATURE) begin
            unique case (sel)
               `PF_SUSPEND: begin
                  dec_port = 1'b1;
                  dec_cmd  = PC_SUSPEND;
               end
               `PF_RESET: begin
                  dec_port = 1'b1;
                  dec_cmd  = PC_RESET;
               end
               `PF_POWER: begin
                  dec_port = 1'b1;
                  dec_cmd  = PC_POWER_ON;
               end
               default: dec_port = 1'b0;
            endcase
         end else begin
            unique case (sel)
               `PF_ENABLE: begin
                  dec_port = 1'b1;
                  dec_cmd  = PC_DISABLE;
               end
               `PF_SUSPEND: begin
                  dec_port = 1'b1;
                  dec_cmd  = PC_RESUME;
               end
               `PF_POWER: begin
                  dec_port = 1'b1;
                  dec_cmd  = PC_POWER_OFF;
               end
               default: begin
                  if (sel >= `PF_C_FIRST && sel <= `PF_C_LAST) begin
                     dec_port = 1'b1;
                     dec_cmd  = PC_CLR_CHG;
                     dec_chg  = sel[2:0];
                  end
               end
            endcase
         end
      end
      // Data requests with zero length degrade to a bare status stage
      if (dec_data && setup_length == 16'h0000) begin
         dec_data = 1'b0;
         dec_ack  = 1'b1;
      end
   end

   // ************************************************
   // Reply sequencer
   // ************************************************
   req_state_t  state_q, state_d;
   reply_kind_t kind_q, kind_d;
   logic [4:0]  idx_q, idx_d;
   logic [4:0]  last_q, last_d;
   logic [7:0]  data_q, data_d;
   logic        ack_q, ack_d;
   logic        stall_q, stall_d;
   logic        pcv_q, pcv_d;
   port_cmd_t   pcmd_q, pcmd_d;
   logic [2:0]  pnum_q, pnum_d;
   logic [2:0]  chg_q, chg_d;
   logic [2:0]  spn_q, spn_d;
   logic [7:0]  send_len;

   // Host may ask for fewer bytes than the descriptor holds
   assign send_len = (setup_length < {8'h00, dec_len}) ? setup_length[7:0] : dec_len;

   always_comb begin
      state_d = state_q;
      kind_d  = kind_q;
      idx_d   = idx_q;
      last_d  = last_q;
      data_d  = data_q;
      ack_d   = 1'b0;
      stall_d = 1'b0;
      pcv_d   = 1'b0;
      pcmd_d  = pcmd_q;
      pnum_d  = pnum_q;
      chg_d   = chg_q;
      spn_d   = spn_q;
      unique case (state_q)
         ST_IDLE: begin
            if (setup_valid) begin
               if (dec_data) begin
                  state_d = ST_SEND;
                  kind_d  = dec_kind;
                  idx_d   = 5'h00;
                  last_d  = 5'(send_len - 8'h01);
                  data_d  = reply_byte(dec_kind, 5'h00);
                  spn_d   = setup_index[2:0];
               end else if (dec_ack) begin
                  ack_d  = 1'b1;
                  pcv_d  = dec_port;
                  pcmd_d = dec_cmd;
                  pnum_d = setup_index[2:0];
                  chg_d  = dec_chg;
               end else begin
                  stall_d = 1'b1;
               end
            end
         end
         ST_SEND: begin
            if (tx_ready) begin
               if (idx_q == last_q) begin
                  state_d = ST_IDLE;
               end else begin
                  idx_d  = idx_q + 5'h01;
                  data_d = reply_byte(kind_q, idx_q + 5'h01);
               end
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= ST_IDLE;
         kind_q  <= K_DEVICE;
         idx_q   <= 5'h00;
         last_q  <= 5'h00;
         data_q  <= 8'h00;
         ack_q   <= 1'b0;
         stall_q <= 1'b0;
         pcv_q   <= 1'b0;
         pcmd_q  <= PC_DISABLE;
         pnum_q  <= 3'h0;
         chg_q   <= 3'h0;
         spn_q   <= 3'h0;
      end else begin
         state_q <= state_d;
         kind_q  <= kind_d;
         idx_q   <= idx_d;
         last_q  <= last_d;
         data_q  <= data_d;
         ack_q   <= ack_d;
         stall_q <= stall_d;
         pcv_q   <= pcv_d;
         pcmd_q  <= pcmd_d;
         pnum_q  <= pnum_d;
         chg_q   <= chg_d;
         spn_q   <= spn_d;
      end
   end

   // ************************************************
   // Outputs
   // ************************************************
   // Port status is sampled live while streaming; the owner keeps it steady
   assign setup_ready    = (state_q == ST_IDLE);
   assign tx_valid       = (state_q == ST_SEND);
   assign tx_data        = data_q;
   assign tx_last        = (state_q == ST_SEND) && (idx_q == last_q);
   assign reply_ack      = ack_q;
   assign reply_stall    = stall_q;
   assign port_cmd_valid = pcv_q;
   assign port_cmd       = pcmd_q;
   assign port_num       = pnum_q;
   assign change_sel     = chg_q;
   assign status_port    = spn_q;

endmodule

// ### dv/hub_req_properties.sv
`timescale 1ns/1ps
module hub_req_properties
   import hub_req_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        arst_n,
   input wire logic        setup_valid,
   input wire logic [7:0]  setup_type,
   input wire logic [7:0]  setup_code,
   input wire logic [15:0] setup_value,
   input wire logic [15:0] setup_length,
   input wire logic        setup_ready,
   input wire logic        reply_ack,
   input wire logic        reply_stall,
   input wire logic        tx_valid,
   input wire logic        tx_ready,
   input wire logic [7:0]  tx_data,
   input wire logic        tx_last,
   input wire logic [2:0]  downstream_line_pair,
   input wire logic        port_cmd_valid,
   input wire logic [2:0]  port_num
);
   // ******************
   // Helpers
   // ******************
   logic [2:0] num_ports;
   always_comb begin
      num_ports = (downstream_line_pair < 3'h2) ? 3'h2 : downstream_line_pair;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   sequence s_take;
      setup_valid && setup_ready;
   endsequence
   sequence s_hub_desc;
      s_take ##0 (setup_type == 8'hA0 && setup_code == 8'h06 && setup_length != 16'h0000
                  && (setup_value[15:8] == 8'h00 || setup_value[15:8] == 8'h29));
   endsequence
   sequence s_final;
      tx_valid && tx_ready && tx_last;
   endsequence
   // ******************
   // Checks
   // ******************
   one_answer_a: assert property (s_take |=> reply_ack || reply_stall || tx_valid)
      else $error("setup left without answer");
   answer_excl_a: assert property (!(reply_ack && reply_stall))
      else $error("ack and stall together");
   ack_cause_a: assert property (reply_ack |-> $past(setup_valid && setup_ready))
      else $error("ack without a setup");
   cmd_with_ack_a: assert property (port_cmd_valid |-> reply_ack && !tx_valid)
      else $error("port command without ack");
   port_range_a: assert property (port_cmd_valid |-> port_num != 3'h0
                                  && port_num <= num_ports)
      else $error("port number out of range");
   ready_idle_a: assert property (setup_ready == !tx_valid)
      else $error("ready wrong while streaming");
   hold_data_a: assert property (tx_valid && !tx_ready |=> tx_valid
                                 && $stable(tx_data) && $stable(tx_last))
      else $error("byte changed while stalled");
   last_drop_a: assert property (s_final |=> !tx_valid)
      else $error("stream continued after last");
   hub_first_a: assert property (s_hub_desc |=> tx_valid && tx_data == 8'h09)
      else $error("hub descriptor first byte wrong");
   bus_stat_stall_a: assert property (s_take ##0 setup_code == 8'h02 |=> reply_stall)
      else $error("bus status not stalled");
endmodule

bind hub_req_unit hub_req_properties chk (
   .core_clk(core_clk), .arst_n(arst_n), .setup_valid(setup_valid), .setup_type(setup_type),
   .setup_code(setup_code), .setup_value(setup_value), .setup_length(setup_length),
   .setup_ready(setup_ready), .reply_ack(reply_ack), .reply_stall(reply_stall),
   .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last),
   .downstream_line_pair(downstream_line_pair), .port_cmd_valid(port_cmd_valid),
   .port_num(port_num)
);

// ### dv/usb_host_model.sv
`timescale 1ns/1ps
module usb_host_model (
   input  wire logic       core_clk,
   input  wire logic       arst_n,
   input  wire logic       slow,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_last,
   output logic            tx_ready
);
   logic [8:0] rx_buf [0:1023];
   int         rx_cnt;
   logic       pace_q;
   // Slow host is ready every other cycle, so the hold path gets exercised
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pace_q <= 1'b0;
         rx_cnt <= 0;
      end else begin
         pace_q <= ~pace_q;
         if (tx_valid && tx_ready) begin
            rx_buf[rx_cnt] <= {tx_last, tx_data};
            rx_cnt         <= rx_cnt + 1;
         end
      end
   end
   assign tx_ready = slow ? pace_q : 1'b1;
endmodule

// ### dv/usb_hub_request_descriptor_unit_test.sv
`timescale 1ns/1ps
module usb_hub_request_descriptor_unit_test;
   import hub_req_pkg::*;
   localparam logic [15:0] REL = 16'h0203;  // Arbitrary
   localparam logic [15:0] VID = 16'h1A2B;  // Arbitrary
   localparam logic [15:0] PID = 16'h3C4D;  // Arbitrary
   logic        core_clk, arst_n, setup_valid, setup_ready, reply_ack, reply_stall, slow;
   logic        tx_valid, tx_ready, tx_last, pwr_src, indv, opt, str_en, long_pg;
   logic        port_cmd_valid;
   logic [7:0]  setup_type, setup_code, tx_data;
   logic [15:0] setup_value, setup_index, setup_length;
   logic [2:0]  dl_pair, status_port, port_num, change_sel;
   logic [1:0]  mps;
   logic [31:0] hub_st, port_st;
   port_cmd_t   port_cmd;
   int          num_errors, check_count;
   logic [7:0]  exp [$];
   // Entry: code nibble, selector, command expected, command
   logic [15:0] pf [18] = '{16'h1018, 16'h3029, 16'h102A, 16'h304B, 16'h1040, 16'h308C,
      16'h108D, 16'h110E, 16'h111E, 16'h112E, 16'h113E, 16'h114E, 16'h3100, 16'h3000,
      16'h1030, 16'h3090, 16'h3010, 16'h3140};
   // Entry: ack expected, then the eight setup bytes
   logic [64:0] nd [13] = '{{1'b0, 64'hA302_0000_0001_0001}, {1'b0, 64'h2001_0001_0000_0000},
      {1'b0, 64'hA001_0001_0000_0000}, {1'b0, 64'h2007_0000_0000_003E},
      {1'b0, 64'hA003_0000_0000_0000}, {1'b0, 64'h2003_0001_0000_0000},
      {1'b0, 64'h2303_0008_0000_0000}, {1'b0, 64'h2303_0008_0004_0000},
      {1'b0, 64'h4005_0000_0000_0000}, {1'b0, 64'h8006_0301_0000_0040},
      {1'b1, 64'h2001_0000_0000_0000}, {1'b1, 64'hA001_0000_0000_0000},
      {1'b1, 64'h8006_0200_0000_0000}};

   hub_req_unit #(.DEVICE_RELEASE(REL)) dut (
      .core_clk(core_clk), .arst_n(arst_n), .setup_valid(setup_valid),
      .setup_type(setup_type), .setup_code(setup_code), .setup_value(setup_value),
      .setup_index(setup_index), .setup_length(setup_length), .setup_ready(setup_ready),
      .reply_ack(reply_ack), .reply_stall(reply_stall), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last),
      .power_source_strap(pwr_src), .individual_pwr_strap(indv), .option_strap(opt),
      .downstream_line_pair(dl_pair), .vendor_id(VID), .product_id(PID),
      .strings_enable(str_en), .long_power_good(long_pg), .max_power_sel(mps),
      .hub_status_in(hub_st), .port_status_in(port_st), .status_port(status_port),
      .port_cmd_valid(port_cmd_valid), .port_cmd(port_cmd), .port_num(port_num),
      .change_sel(change_sel));
   usb_host_model host (.core_clk(core_clk), .arst_n(arst_n), .slow(slow),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // ******************
   // Access tasks
   // ******************
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic req(input logic [63:0] r);
      int n;
      n = 0;
      while (setup_ready !== 1'b1 && n < 100) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      chk("setup_ready", 1'b1, setup_ready);
      @(posedge core_clk);
      {setup_type, setup_code, setup_value, setup_index, setup_length} <= r;
      setup_valid <= 1'b1;
      @(posedge core_clk);
      setup_valid <= 1'b0;
      #1;
   endtask

   task automatic nodata(input logic [63:0] r, input logic a);
      req(r);
      chk("reply_ack", a, reply_ack);
      chk("reply_stall", !a, reply_stall);
      chk("port_cmd_valid", 1'b0, port_cmd_valid);
   endtask

   task automatic get(input logic [63:0] r);
      int base, n;
      base = host.rx_cnt;
      n = 0;
      req(r);
      while (tx_valid === 1'b1 && n < 300) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      chk("tx_valid", 1'b0, tx_valid);
      chk("byte count", exp.size(), host.rx_cnt - base);
      foreach (exp[k]) begin
         chk("byte", exp[k], host.rx_buf[base + k][7:0]);
         chk("last flag", k == exp.size() - 1, host.rx_buf[base + k][8]);
      end
   endtask

   task automatic pfeat(input logic [15:0] e, input logic dir, input logic [2:0] p);
      req({dir, 7'h23, 4'h0, e[15:12], 8'h00, e[11:4], 13'h0000, p, 16'h0000});
      chk("reply_ack", 1'b1, reply_ack);
      chk("port_cmd_valid", e[3], port_cmd_valid);
      if (e[3]) begin
         chk("port_cmd", e[2:0], port_cmd);
         chk("port_num", p, port_num);
         if (e[2:0] == 3'h6) begin
            chk("change_sel", e[6:4], change_sel);
         end
      end
   endtask

   task automatic summarize();
      if (num_errors == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      #200000;
      num_errors++;
      summarize();
   end

   // ******************
   // Tests
   // ******************
   initial begin
      {arst_n, setup_valid, setup_type, setup_code, setup_value, setup_index} = '0;
      {setup_length, pwr_src, indv, opt, str_en, long_pg, slow, mps} = '0;
      {dl_pair, hub_st, port_st} = '0;
      repeat (4) @(posedge core_clk);
      arst_n <= 1'b1;
      for (int m = 0; m < 8; m++) begin
         @(posedge core_clk);
         {indv, opt, pwr_src} <= m[2:0];
         dl_pair <= 3'(2 + m % 4);
         long_pg <= m[2];
         slow <= m[1];
         exp = '{8'h09, 8'h29, 8'(2 + m % 4), (m % 4 == 2) ? 8'h11 : 8'h09, 8'h00,
                 (m % 4 == 3) ? 8'h00 : (m[2] ? 8'hFA : 8'h32), 8'h64, 8'h00, 8'hFF};
         get({16'hA006, m[0] ? 16'h2900 : 16'h0, 32'h40});
      end
      exp = '{8'h09, 8'h29, 8'h05, 8'h09};
      get(64'hA006_0000_0000_0004);
      for (int s = 0; s < 2; s++) begin
         @(posedge core_clk);
         str_en <= s[0];
         slow <= s[0];
         exp = '{8'h12, 8'h01, 8'h10, 8'h01, 8'h09, 8'h00, 8'h00, 8'h40, VID[7:0], VID[15:8],
                 PID[7:0], PID[15:8], REL[7:0], REL[15:8], s[0] ? 8'h01 : 8'h00,
                 s[0] ? 8'h02 : 8'h00, 8'h00, 8'h01};
         get(64'h8006_0100_0000_0040);
      end
      exp = '{8'h04, 8'h03, 8'h09, 8'h04};
      get(64'h8006_0300_0000_00FF);
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk);
         pwr_src <= i[0];
         mps <= i[1:0];
         exp = '{8'h09, 8'h02, 8'h19, 8'h00, 8'h01, 8'h01, 8'h00, i[0] ? 8'hE0 : 8'hA0,
                 (i == 1) ? 8'h00 : ((i == 2) ? 8'hFA : 8'h32), 8'h09, 8'h04, 8'h00, 8'h01,
                 8'h01, 8'h09, 8'h00, 8'h00, 8'h00, 8'h07, 8'h05, 8'h81, 8'h03, 8'h01, 8'h00,
                 8'hFF};
         get(64'h8006_0200_0000_0040);
      end
      @(posedge core_clk);
      hub_st <= 32'h0003_0001;
      port_st <= 32'h0011_0103;
      dl_pair <= 3'h3;
      str_en <= 1'b0;
      exp = '{8'h01, 8'h00, 8'h03, 8'h00};
      get(64'hA000_0000_0000_0004);
      exp = '{8'h03, 8'h01, 8'h11, 8'h00};
      get(64'hA300_0000_0002_0004);
      chk("status_port", 3'h2, status_port);
      foreach (pf[k]) begin
         pfeat(pf[k], k[0], 3'((k % 3) + 1));
      end
      foreach (nd[k]) begin
         nodata(nd[k][63:0], nd[k][64]);
      end
      summarize();
   end
endmodule
